// file: design/sbs_pkg.sv
package sbs_pkg;

	// ----------------------------------------------------------------
	// Scan chain geometry
	// ----------------------------------------------------------------
	localparam int         BSR_LEN      = 109;
	localparam int         OE_CELL      = 108;
	localparam int         IR_W         = 3;
	localparam int         ID_W         = 32;
	localparam int         RESET_EDGES  = 5;

	// ----------------------------------------------------------------
	// Instruction codes and fixed patterns
	// ----------------------------------------------------------------
	localparam logic [2:0] IR_EXTEST    = 3'h0;
	localparam logic [2:0] IR_IDCODE    = 3'h1;
	localparam logic [2:0] IR_SAMPLE_Z  = 3'h2;
	localparam logic [2:0] IR_SAMPLE    = 3'h4;
	localparam logic [2:0] IR_BYPASS    = 3'h7;
	localparam logic [2:0] IR_CAPTURE   = 3'h1;
	// Arbitrary neutral identity value
	localparam logic [31:0] ID_CODE_DEF = 32'h0A5A_5001;

	// ----------------------------------------------------------------
	// Controller states
	// ----------------------------------------------------------------
	typedef enum logic [15:0] {
		ST_TLR    = 16'h0001,
		ST_RTI    = 16'h0002,
		ST_SEL_DR = 16'h0004,
		ST_CAP_DR = 16'h0008,
		ST_SH_DR  = 16'h0010,
		ST_EX1_DR = 16'h0020,
		ST_PA_DR  = 16'h0040,
		ST_EX2_DR = 16'h0080,
		ST_UP_DR  = 16'h0100,
		ST_SEL_IR = 16'h0200,
		ST_CAP_IR = 16'h0400,
		ST_SH_IR  = 16'h0800,
		ST_EX1_IR = 16'h1000,
		ST_PA_IR  = 16'h2000,
		ST_EX2_IR = 16'h4000,
		ST_UP_IR  = 16'h8000
	} sbs_state_e;

endpackage : sbs_pkg

// file: design/sbs_sync.sv
`timescale 1ns/1ps
module sbs_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	// Asynchronous inputs
	input  wire logic [W-1:0] async_in,
	// Synchronised levels and edge pulses
	output logic      [W-1:0] level_out,
	output logic      [W-1:0] rise_out,
	output logic      [W-1:0] fall_out
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
	} sbs_sync_s;

	sbs_sync_s r;
	sbs_sync_s next_r;

	always_comb begin
		next_r    = r;
		next_r.s1 = async_in;
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// Edges seen between second and third stage only
	assign level_out = r.s2;
	assign rise_out  = r.s2 & ~r.s3;
	assign fall_out  = ~r.s2 & r.s3;

endmodule : sbs_sync

// file: design/sbs_tap.sv
// Behaviour
// - Undriven mode select or data in reads as high.
// - Power-up puts test logic in reset without touching memory.
// - Inputs taken at test clock rise, serial output launched at its fall; ring_out loads at a rise.
// - Controller steps on mode select sampled each rising test clock.
// - Current instruction selects the register between data in and out.
// - Scan registers shift from top bit down; output from bit zero.
// - Serial output drives only in shift states, else floats.
// - Five rises with mode select high reach reset from anywhere.
// - Test port reset never touches memory, allowed any time.
// - Power-up reset leaves serial output floating.
// - Only one scan register sits in the serial path at once.
// - Instruction register is three bits, loaded serially in shift.
// - Identification instruction loaded at power-up and in reset state.
// - Instruction capture loads pattern 01 into the two low bits.
// - Bypass register is one bit, a single-stage path.
// - Bypass bit cleared when bypass instruction takes effect.
// - Boundary chain has a cell per pin plus reserved cells.
// - Data capture loads pin ring into boundary chain, then shifts.
// - Ring capture under external test, sample and sample-floated.
// - New instruction takes effect only through instruction update or the reset state.
// - Sample-floated holds read data outputs floating until replaced.
// - Cell 108 gates read data output enable under external test.
// - Identification register holds fixed 32-bit code captured in DR.
`timescale 1ns/1ps
module sbs_tap #(
	parameter int          BSR_LEN = sbs_pkg::BSR_LEN,
	parameter logic [31:0] ID_CODE = sbs_pkg::ID_CODE_DEF
) (
	// Clock and reset
	input  wire logic               core_clk_in,
	input  wire logic               rst_in,
	// Test pins
	input  wire logic               tck_in,
	input  wire logic               tms_in,
	input  wire logic               tms_driven_in,
	input  wire logic               tdi_in,
	input  wire logic               tdi_driven_in,
	output logic                    tdo_out,
	output logic                    tdo_oe_out,
	// Pin ring
	input  wire logic [BSR_LEN-1:0] ring_in,
	output logic      [BSR_LEN-1:0] ring_out,
	output logic                    extest_out,
	// Read data output enable
	input  wire logic               mem_q_oe_in,
	output logic                    q_oe_out
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [sbs_pkg::IR_W-1:0] ir_sh;
		logic [sbs_pkg::IR_W-1:0] ir;
		logic                     byp;
		logic [sbs_pkg::ID_W-1:0] id_sh;
		logic [BSR_LEN-1:0]       bsr;
		logic [BSR_LEN-1:0]       pre;
		logic                     tdo;
		logic                     tdo_oe;
		logic                     q_oe;
		logic                     extest;
	} sbs_tap_s;

	sbs_tap_s r;
	sbs_tap_s next_r;

	logic [2:0]          pin_lvl;
	logic [2:0]          pin_rise;
	logic [2:0]          pin_fall;
	logic [BSR_LEN-1:0]  ring_s;
	sbs_pkg::sbs_state_e st;
	logic                tck_rise;
	logic                tck_fall;
	logic                tms_s;
	logic                tdi_s;
	logic                tms_pin;
	logic                tdi_pin;

	// ----------------------------------------------------------------
	// Register selection
	// ----------------------------------------------------------------
	function automatic logic uses_bsr(input logic [2:0] ir);
		uses_bsr = (ir == sbs_pkg::IR_EXTEST) || (ir == sbs_pkg::IR_SAMPLE)
			|| (ir == sbs_pkg::IR_SAMPLE_Z);
	endfunction : uses_bsr

	function automatic logic uses_id(input logic [2:0] ir);
		uses_id = (ir == sbs_pkg::IR_IDCODE);
	endfunction : uses_id

	// ----------------------------------------------------------------
	// Pin conditioning and sampling
	// ----------------------------------------------------------------
	assign tms_pin = tms_driven_in ? tms_in : 1'b1;
	assign tdi_pin = tdi_driven_in ? tdi_in : 1'b1;

	sbs_sync #(
		.W (3)
	) u_pin_sync (
		.clk_in    (core_clk_in),
		.rst_in    (rst_in),
		.async_in  ({tck_in, tms_pin, tdi_pin}),
		.level_out (pin_lvl),
		.rise_out  (pin_rise),
		.fall_out  (pin_fall)
	);

	sbs_sync #(
		.W (BSR_LEN)
	) u_ring_sync (
		.clk_in    (core_clk_in),
		.rst_in    (rst_in),
		.async_in  (ring_in),
		.level_out (ring_s),
		.rise_out  (),
		.fall_out  ()
	);

	assign tck_rise = pin_rise[2];
	assign tck_fall = pin_fall[2];
	assign tms_s    = pin_lvl[1];
	assign tdi_s    = pin_lvl[0];

	sbs_tap_fsm u_fsm (
		.clk_in    (core_clk_in),
		.rst_in    (rst_in),
		.step_in   (tck_rise),
		.tms_in    (tms_s),
		.state_out (st)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_r = r;
		if (tck_rise) begin
			case (st)
				sbs_pkg::ST_CAP_DR: begin
					if (uses_id(r.ir)) begin
						next_r.id_sh = ID_CODE;
					end else if (uses_bsr(r.ir)) begin
						next_r.bsr = ring_s;
					end else begin
						next_r.byp = 1'b0;
					end
				end
				sbs_pkg::ST_SH_DR: begin
					// One register moves per shift
					if (uses_id(r.ir)) begin
						next_r.id_sh = {tdi_s, r.id_sh[sbs_pkg::ID_W-1:1]};
					end else if (uses_bsr(r.ir)) begin
						next_r.bsr = {tdi_s, r.bsr[BSR_LEN-1:1]};
					end else begin
						next_r.byp = tdi_s;
					end
				end
				sbs_pkg::ST_UP_DR: begin
					if (uses_bsr(r.ir)) begin
						next_r.pre = r.bsr;
					end
				end
				sbs_pkg::ST_CAP_IR: begin
					next_r.ir_sh = sbs_pkg::IR_CAPTURE;
				end
				sbs_pkg::ST_SH_IR: begin
					next_r.ir_sh = {tdi_s, r.ir_sh[sbs_pkg::IR_W-1:1]};
				end
				sbs_pkg::ST_UP_IR: begin
					next_r.ir = r.ir_sh;
					if (r.ir_sh == sbs_pkg::IR_BYPASS) begin
						next_r.byp = 1'b0;
					end
				end
				default: begin
					next_r.ir = r.ir;
				end
			endcase
		end
		// Reset state forces the instruction as soon as it is entered
		if (st == sbs_pkg::ST_TLR) begin
			next_r.ir                    = sbs_pkg::IR_IDCODE;
			next_r.pre[sbs_pkg::OE_CELL] = 1'b0;
		end
		if (tck_fall) begin
			next_r.tdo_oe = (st == sbs_pkg::ST_SH_DR)
				|| (st == sbs_pkg::ST_SH_IR);
			if (st == sbs_pkg::ST_SH_IR) begin
				next_r.tdo = r.ir_sh[0];
			end else if (uses_id(r.ir)) begin
				next_r.tdo = r.id_sh[0];
			end else if (uses_bsr(r.ir)) begin
				next_r.tdo = r.bsr[0];
			end else begin
				next_r.tdo = r.byp;
			end
		end
		// Memory path passes through unless a test instruction owns it
		if (r.ir == sbs_pkg::IR_SAMPLE_Z) begin
			next_r.q_oe = 1'b0;
		end else if (r.ir == sbs_pkg::IR_EXTEST) begin
			next_r.q_oe = r.pre[sbs_pkg::OE_CELL];
		end else begin
			next_r.q_oe = mem_q_oe_in;
		end
		next_r.extest = (r.ir == sbs_pkg::IR_EXTEST);
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			r        <= '0;
			r.ir     <= sbs_pkg::IR_IDCODE;
			r.tdo_oe <= 1'b0;
		end else begin
			r <= next_r;
		end
	end

	assign tdo_out    = r.tdo;
	assign tdo_oe_out = r.tdo_oe;
	assign ring_out   = r.pre;
	assign extest_out = r.extest;
	assign q_oe_out   = r.q_oe;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [2:0] tms_hi_cnt;

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			tms_hi_cnt <= 3'h0;
		end else if (tck_rise) begin
			if (!tms_s) begin
				tms_hi_cnt <= 3'h0;
			end else if (tms_hi_cnt != 3'h7) begin
				tms_hi_cnt <= tms_hi_cnt + 3'h1;
			end
		end
	end

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);

	property p_five_reset;
		tms_hi_cnt >= 3'h5 |-> st == sbs_pkg::ST_TLR;
	endproperty
	a_five_reset: assert property (p_five_reset)
		else $error("five high mode edges did not reach reset");

	property p_oe_shift;
		$rose(tdo_oe_out) |-> $past(tck_fall) && ($past(st) == sbs_pkg::ST_SH_DR
			|| $past(st) == sbs_pkg::ST_SH_IR);
	endproperty
	a_oe_shift: assert property (p_oe_shift)
		else $error("serial output enabled outside shift");

	property p_tdo_fall;
		$changed(tdo_out) || $changed(tdo_oe_out) |-> $past(tck_fall);
	endproperty
	a_tdo_fall: assert property (p_tdo_fall)
		else $error("serial output moved off a falling edge");

	property p_tlr_id;
		st == sbs_pkg::ST_TLR |=> r.ir == sbs_pkg::IR_IDCODE
			&& !r.pre[sbs_pkg::OE_CELL];
	endproperty
	a_tlr_id: assert property (p_tlr_id)
		else $error("reset state did not load identification");

	property p_cap_ir;
		tck_rise && st == sbs_pkg::ST_CAP_IR |=> r.ir_sh[1:0] == 2'h1;
	endproperty
	a_cap_ir: assert property (p_cap_ir)
		else $error("instruction capture pattern wrong");

	property p_ir_update;
		$changed(r.ir) |-> ($past(tck_rise) && $past(st) == sbs_pkg::ST_UP_IR)
			|| $past(st) == sbs_pkg::ST_TLR;
	endproperty
	a_ir_update: assert property (p_ir_update)
		else $error("instruction changed outside update");

	property p_ir_shift;
		tck_rise && st == sbs_pkg::ST_SH_IR |=>
			r.ir_sh == {$past(tdi_s), $past(r.ir_sh[2:1])};
	endproperty
	a_ir_shift: assert property (p_ir_shift)
		else $error("instruction shift direction wrong");

	property p_float_z;
		r.ir == sbs_pkg::IR_SAMPLE_Z |=> !q_oe_out;
	endproperty
	a_float_z: assert property (p_float_z)
		else $error("read outputs enabled under sample-floated");

	property p_extest_cell;
		r.ir == sbs_pkg::IR_EXTEST |=>
			q_oe_out == $past(r.pre[sbs_pkg::OE_CELL]);
	endproperty
	a_extest_cell: assert property (p_extest_cell)
		else $error("output enable does not follow cell 108");

	property p_id_cap;
		tck_rise && st == sbs_pkg::ST_CAP_DR && r.ir == sbs_pkg::IR_IDCODE
			|=> r.id_sh == ID_CODE;
	endproperty
	a_id_cap: assert property (p_id_cap)
		else $error("identification code not captured");

endmodule : sbs_tap

// file: design/sbs_tap_fsm.sv
`timescale 1ns/1ps
module sbs_tap_fsm (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// Test clock rise and mode select
	input  wire logic        step_in,
	input  wire logic        tms_in,
	// Current state
	output sbs_pkg::sbs_state_e state_out
);

	typedef struct packed {
		sbs_pkg::sbs_state_e st;
	} sbs_fsm_s;

	sbs_fsm_s r;
	sbs_fsm_s next_r;

	always_comb begin
		next_r = r;
		if (step_in) begin
			case (r.st)
				sbs_pkg::ST_TLR:    next_r.st = tms_in ? sbs_pkg::ST_TLR
					: sbs_pkg::ST_RTI;
				sbs_pkg::ST_RTI:    next_r.st = tms_in ? sbs_pkg::ST_SEL_DR
					: sbs_pkg::ST_RTI;
				sbs_pkg::ST_SEL_DR: next_r.st = tms_in ? sbs_pkg::ST_SEL_IR
					: sbs_pkg::ST_CAP_DR;
				sbs_pkg::ST_CAP_DR: next_r.st = tms_in ? sbs_pkg::ST_EX1_DR
					: sbs_pkg::ST_SH_DR;
				sbs_pkg::ST_SH_DR:  next_r.st = tms_in ? sbs_pkg::ST_EX1_DR
					: sbs_pkg::ST_SH_DR;
				sbs_pkg::ST_EX1_DR: next_r.st = tms_in ? sbs_pkg::ST_UP_DR
					: sbs_pkg::ST_PA_DR;
				sbs_pkg::ST_PA_DR:  next_r.st = tms_in ? sbs_pkg::ST_EX2_DR
					: sbs_pkg::ST_PA_DR;
				sbs_pkg::ST_EX2_DR: next_r.st = tms_in ? sbs_pkg::ST_UP_DR
					: sbs_pkg::ST_SH_DR;
				sbs_pkg::ST_UP_DR:  next_r.st = tms_in ? sbs_pkg::ST_SEL_DR
					: sbs_pkg::ST_RTI;
				sbs_pkg::ST_SEL_IR: next_r.st = tms_in ? sbs_pkg::ST_TLR
					: sbs_pkg::ST_CAP_IR;
				sbs_pkg::ST_CAP_IR: next_r.st = tms_in ? sbs_pkg::ST_EX1_IR
					: sbs_pkg::ST_SH_IR;
				sbs_pkg::ST_SH_IR:  next_r.st = tms_in ? sbs_pkg::ST_EX1_IR
					: sbs_pkg::ST_SH_IR;
				sbs_pkg::ST_EX1_IR: next_r.st = tms_in ? sbs_pkg::ST_UP_IR
					: sbs_pkg::ST_PA_IR;
				sbs_pkg::ST_PA_IR:  next_r.st = tms_in ? sbs_pkg::ST_EX2_IR
					: sbs_pkg::ST_PA_IR;
				sbs_pkg::ST_EX2_IR: next_r.st = tms_in ? sbs_pkg::ST_UP_IR
					: sbs_pkg::ST_SH_IR;
				sbs_pkg::ST_UP_IR:  next_r.st = tms_in ? sbs_pkg::ST_SEL_DR
					: sbs_pkg::ST_RTI;
				default:            next_r.st = sbs_pkg::ST_TLR;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			r.st <= sbs_pkg::ST_TLR;
		end else begin
			r <= next_r;
		end
	end

	assign state_out = r.st;

endmodule : sbs_tap_fsm

// file: verif/sbs_tester.sv
`timescale 1ns/1ps
module sbs_tester (
	// Core clock for pacing
	input  wire logic clk_in,
	// Test pins
	output logic      tck_out,
	output logic      tms_out,
	output logic      tms_driven_out,
	output logic      tdi_out,
	output logic      tdi_driven_out,
	input  wire logic tdo_in,
	input  wire logic tdo_oe_in
);

	// ----------------------------------------------------------------
	// Idle pins
	// ----------------------------------------------------------------
	initial begin
		tck_out        = 1'b0;
		tms_out        = 1'b1;
		tms_driven_out = 1'b1;
		tdi_out        = 1'b0;
		tdi_driven_out = 1'b1;
	end

	// ----------------------------------------------------------------
	// One 900 ns test clock period; floating pins toggle garbage
	// ----------------------------------------------------------------
	task automatic step(input logic m, input logic d, input logic flt,
		output logic q);
		@(posedge clk_in);
		tms_out        <= flt ? ~tms_out : m;
		tms_driven_out <= ~flt;
		tdi_out        <= flt ? ~tdi_out : d;
		tdi_driven_out <= ~flt;
		repeat (4) @(posedge clk_in);
		tck_out <= 1'b1;
		q = (tdo_oe_in === 1'b1) ? tdo_in : 1'bz;
		repeat (4) @(posedge clk_in);
		tck_out <= 1'b0;
	endtask : step

endmodule : sbs_tester

// file: verif/tb_sbs_tap.sv
`timescale 1ns/1ps
module tb_sbs_tap;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic         clk;
	logic         rst_in;
	logic         tck, tms, tms_drv, tdi, tdi_drv, tdo, tdo_oe;
	logic [108:0] ring_in, ring_out;
	logic         extest_out, mem_q_oe_in, q_oe_out;
	int           err_total, check_count, seed, st;
	logic [2:0]   ir, irs;
	logic [108:0] dr, pre, ring;
	int n0[16] = '{1, 1, 3, 4, 4, 6, 6, 4, 1, 10, 11, 11, 13, 13, 11, 1};
	int n1[16] = '{0, 2, 9, 5, 5, 8, 7, 8, 2, 0, 12, 12, 15, 14, 15, 2};
	logic [2:0] codes[9] = '{3'h4, 3'h0, 3'h0, 3'h1, 3'h7, 3'h3, 3'h5,
		3'h6, 3'h2};

	sbs_tap sbs_tap_inst (
		.core_clk_in   (clk),
		.rst_in        (rst_in),
		.tck_in        (tck),
		.tms_in        (tms),
		.tms_driven_in (tms_drv),
		.tdi_in        (tdi),
		.tdi_driven_in (tdi_drv),
		.tdo_out       (tdo),
		.tdo_oe_out    (tdo_oe),
		.ring_in       (ring_in),
		.ring_out      (ring_out),
		.extest_out    (extest_out),
		.mem_q_oe_in   (mem_q_oe_in),
		.q_oe_out      (q_oe_out)
	);

	sbs_tester sbs_tester_inst (
		.clk_in         (clk),
		.tck_out        (tck),
		.tms_out        (tms),
		.tms_driven_out (tms_drv),
		.tdi_out        (tdi),
		.tdi_driven_out (tdi_drv),
		.tdo_in         (tdo),
		.tdo_oe_in      (tdo_oe)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Compare and closing tasks
	// ----------------------------------------------------------------
	task automatic cmp_bit(input string nm, input logic e, input logic g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %b seen %b", nm, e, g);
		end
	endtask : cmp_bit

	task automatic cmp_vec(input string nm, input logic [108:0] e,
		input logic [108:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp_vec

	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim

	// ----------------------------------------------------------------
	// Reference model of the port
	// ----------------------------------------------------------------
	function automatic int ilen(input logic [2:0] c);
		if (c == sbs_pkg::IR_EXTEST || c == sbs_pkg::IR_SAMPLE ||
			c == sbs_pkg::IR_SAMPLE_Z)
			return sbs_pkg::BSR_LEN;
		return (c == sbs_pkg::IR_IDCODE) ? sbs_pkg::ID_W : 1;
	endfunction : ilen

	function automatic logic [108:0] rnd;
		logic [127:0] t;
		t = {$random(seed), $random(seed), $random(seed), $random(seed)};
		return t[108:0];
	endfunction : rnd

	task automatic step(input logic m, input logic d, input logic flt);
		logic q, e, me, de;
		int   len;
		me  = flt ? 1'b1 : m;
		de  = flt ? 1'b1 : d;
		len = ilen(ir);
		e   = (st == 4) ? dr[0] : (st == 11) ? irs[0] : 1'bz;
		sbs_tester_inst.step(m, d, flt, q);
		cmp_bit("tdo", e, q);
		case (st)
			3: dr = (len == 109) ? ring :
				(len == 32) ? {77'h0, sbs_pkg::ID_CODE_DEF} : 109'h0;
			4: begin
				dr = dr >> 1;
				dr[len-1] = de;
			end
			8: if (len == 109) pre = dr;
			10: irs = 3'h1;
			11: irs = {de, irs[2:1]};
			15: begin
				ir = irs;
				if (ilen(irs) == 1) dr = 109'h0;
			end
			default: ;
		endcase
		st = me ? n1[st] : n0[st];
		if (st == 0) begin
			ir = sbs_pkg::IR_IDCODE;
			pre[108] = 1'b0;
		end
	endtask : step

	// From idle: capture, shift n bits, pause, update, back to idle
	task automatic scan(input bit isir, input int n, input logic [108:0] v);
		step(1'b1, 1'b0, 1'b0);
		if (isir) step(1'b1, 1'b0, 1'b0);
		step(1'b0, 1'b0, 1'b0);
		step(1'b0, 1'b0, 1'b0);
		for (int i = 0; i < n; i++) step(i == n - 1, v[i], 1'b0);
		step(1'b0, 1'b0, 1'b0);
		step(1'b1, 1'b0, 1'b0);
		step(1'b1, 1'b0, 1'b0);
		step(1'b0, 1'b0, 1'b0);
	endtask : scan

	task automatic check_pins(input bit full);
		logic e;
		mem_q_oe_in <= 1'($random(seed));
		repeat (3) @(posedge clk);
		e = (ir == sbs_pkg::IR_SAMPLE_Z) ? 1'b0 :
			(ir == sbs_pkg::IR_EXTEST) ? pre[108] : mem_q_oe_in;
		cmp_bit("q_oe", e, q_oe_out);
		cmp_bit("extest", ir == sbs_pkg::IR_EXTEST, extest_out);
		if (full) cmp_vec("ring_out", pre, ring_out);
	endtask : check_pins

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [108:0] v;
		err_total   = 0;
		check_count = 0;
		seed        = 32'ha59c081e;
		rst_in      = 1'b1;
		ring_in     = '0;
		mem_q_oe_in = 1'b0;
		st  = 0;
		ir  = sbs_pkg::IR_IDCODE;
		irs = 3'h0;
		dr  = '0;
		pre = '0;
		repeat (3) @(posedge clk);
		rst_in <= 1'b0;
		@(posedge clk);
		cmp_bit("tdo_oe", 1'b0, tdo_oe);
		ring = rnd();
		ring_in <= ring;
		step(1'b0, 1'b0, 1'b0);
		scan(1'b0, 32, rnd());
		for (int k = 0; k < 9; k++) begin
			ring = rnd();
			ring_in <= ring;
			scan(1'b1, 3, {106'h0, codes[k]});
			v = rnd();
			v[108] = k[0];
			scan(1'b0, (ilen(ir) == 1) ? 6 : ilen(ir), v);
			check_pins(1'b1);
			$display("test %0d code %0h done", k, codes[k]);
		end
		step(1'b1, 1'b0, 1'b0);
		step(1'b0, 1'b0, 1'b0);
		step(1'b0, 1'b0, 1'b0);
		for (int i = 0; i < 5; i++) step(1'b0, 1'b0, 1'b1);
		check_pins(1'b0);
		step(1'b0, 1'b0, 1'b0);
		scan(1'b0, 32, rnd());
		$display("test float reset done");
		end_sim();
	end

	initial begin
		#5000000;
		err_total++;
		end_sim();
	end

endmodule : tb_sbs_tap
